// ===== hw/opt_timer.sv
// one-shot and pwm timer channel with axi4-lite register slave.
// assumes one core clock; trigger pin and subclock pin are asynchronous
// and are synchronised here; the overflow input is on the core clock.
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module opt_timer
  import opt_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output var  logic              o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output var  logic              o_wready,
  output var  logic [1:0]        o_bresp,
  output var  logic              o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output var  logic              o_arready,
  output var  logic [31:0]       o_rdata,
  output var  logic [1:0]        o_rresp,
  output var  logic              o_rvalid,
  input  wire logic              i_rready,
  input  wire logic              i_trigger_input_pin,
  input  wire logic              i_subclock,
  input  wire logic              i_timer_ovf,
  output var  logic              o_pulse_output_pin,
  output var  logic              o_irq
);
  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------
  // state declarations
  // ---------------------------------------------------------------------
  opt_ctrl_t         ctrl_q;
  logic [15:0]       reload_q;
  logic [1:0]        sts_q;
  logic [1:0]        mask_q;
  logic              gpio_out_q;
  logic              os_sw_q;
  logic              aw_hold_q, w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [31:0]       rdata_q;
  logic [1:0]        sy1_q, sy2_q, sy3_q, stab_q;
  logic [4:0]        div_q, sub_div_q;
  opt_state_t        state_q;
  logic [15:0]       cnt_q, per_q;
  logic [7:0]        pre_q, m_q;
  logic              out_q, pin_q, irq_q;
  logic [1:0]        ev_q;
  logic              wr_fire, cnt_wr;
  logic [31:0]       ctrl_wv, cnt_wv;
  logic              trig_edge, sub_edge, tick, trig_ev, sub_tick;
  logic [15:0]       width_v, top_v;

  // ---------------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------------
  // address and data are taken in either order; response after both
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign cnt_wr  = wr_fire && (awaddr_q == OFF_COUNT);
  assign ctrl_wv = merge({21'h0, ctrl_q}, wdata_q, wstrb_q);
  assign cnt_wv  = merge({16'h0, reload_q}, wdata_q, wstrb_q);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (i_awvalid && awready_q) begin
        aw_hold_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q  <= {i_awaddr[ADDR_W-1:2], 2'b00};
      end
      if (i_wvalid && wready_q) begin
        w_hold_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q  <= i_wdata;
        wstrb_q  <= i_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (awaddr_q > OFF_GPIO) ? RESP_SLVERR : RESP_OKAY;
      end
      // ready returns only after the response, one write at a time
      if (bvalid_q && i_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------------
  // control, reload, mask and gpio; os_start is a one-cycle pulse
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q     <= CTRL_RST;
      reload_q   <= RELOAD_RST;
      mask_q     <= 2'h0;
      gpio_out_q <= 1'b0;
      os_sw_q    <= 1'b0;
    end else begin
      os_sw_q <= wr_fire && (awaddr_q == OFF_CTRL) && ctrl_wv[OS_START_B];
      if (wr_fire && (awaddr_q == OFF_CTRL)) begin
        ctrl_q          <= ctrl_wv[CTRL_W-1:0];
        ctrl_q.os_start <= 1'b0;
      end
      // while running only the reload takes the value
      if (cnt_wr) begin
        reload_q <= cnt_wv[15:0];
      end
      // both mask bits sit in byte lane 0
      if (wr_fire && (awaddr_q == OFF_MASK) && wstrb_q[0]) begin
        mask_q <= wdata_q[1:0];
      end
      if (wr_fire && (awaddr_q == OFF_GPIO) && wstrb_q[0]) begin
        gpio_out_q <= wdata_q[0];
      end
    end
  end

  // status: sticky events, write one to clear, a new event beats the clear
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sts_q <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      if (wr_fire && (awaddr_q == OFF_STATUS) && wstrb_q[0]) begin
        sts_q <= (sts_q & ~wdata_q[1:0]) | ev_q;
      end else begin
        sts_q <= sts_q | ev_q;
      end
      irq_q <= |(sts_q & mask_q);
    end
  end

  // ---------------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------------
  // one-cycle read latency; the count register hides the live count
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else begin
      if (i_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rresp_q   <= RESP_OKAY;
        case ({i_araddr[ADDR_W-1:2], 2'b00})
          OFF_CTRL:   rdata_q <= {21'h0, ctrl_q};
          OFF_COUNT:  rdata_q <= COUNT_RDVAL;
          OFF_STATUS: rdata_q <= {29'h0, state_q != ST_HALT, sts_q};
          OFF_MASK:   rdata_q <= {30'h0, mask_q};
          OFF_GPIO:   rdata_q <= {30'h0, stab_q[0], gpio_out_q};
          default: begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_SLVERR;
          end
        endcase
      end
      if (rvalid_q && i_rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // pin synchronisers and count clock
  // ---------------------------------------------------------------------
  // three stages; a level counts once stages two and three agree
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sy1_q  <= 2'h0;
      sy2_q  <= 2'h0;
      sy3_q  <= 2'h0;
      stab_q <= 2'h0;
    end else begin
      sy1_q <= {i_subclock, i_trigger_input_pin};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      for (int k = 0; k < 2; k++) begin
        if (sy2_q[k] == sy3_q[k]) begin
          stab_q[k] <= sy3_q[k];
        end
      end
    end
  end

  // edges are seen where the agreed level is about to change
  assign trig_edge = (sy2_q[0] == sy3_q[0]) && (sy3_q[0] != stab_q[0])
                     && (sy3_q[0] != ctrl_q.trig_fall);
  assign sub_edge  = (sy2_q[1] == sy3_q[1]) && sy3_q[1] && !stab_q[1];

  // free prescaler for sysclk/8 and /32, edge counter for subclock/32
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q     <= 5'h00;
      sub_div_q <= 5'h00;
    end else begin
      div_q <= div_q + 5'h01;
      if (sub_edge) begin
        sub_div_q <= sub_div_q + 5'h01;
      end
    end
  end

  // selected_count_clock as a one-cycle enable
  always_comb begin
    case (ctrl_q.clk_sel)
      CLK_DIV1:  tick = 1'b1;
      CLK_DIV8:  tick = (div_q[2:0] == DIV8_LAST[2:0]);
      CLK_DIV32: tick = (div_q == DIV32_LAST);
      CLK_SUB32: tick = sub_edge && (sub_div_q == DIV32_LAST);
      default:   tick = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------------
  // counter engine
  // ---------------------------------------------------------------------
  // trigger sources: pin edge or overflow of the other timer
  assign trig_ev  = (ctrl_q.ext_trig_en && trig_edge)
                    || (ctrl_q.ovf_trig_en && i_timer_ovf);
  // pwm counts in units of (m+1) count clocks
  assign sub_tick = tick && (pre_q == 8'h00);
  assign width_v  = ctrl_q.pwm8 ? {8'h00, reload_q[15:8]} : reload_q;
  assign top_v    = ctrl_q.pwm8 ? PER8_TOP : PER16_TOP;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_HALT;
      cnt_q   <= 16'h0000;
      per_q   <= 16'h0000;
      pre_q   <= 8'h00;
      m_q     <= 8'h00;
      out_q   <= 1'b0;
      ev_q    <= 2'h0;
    end else begin
      ev_q <= 2'h0;
      if (!ctrl_q.run) begin
        // clearing the run flag stops either mode
        state_q <= ST_HALT;
        out_q   <= 1'b0;
        if (cnt_wr) begin
          cnt_q <= cnt_wv[15:0];
        end
      end else if (ctrl_q.mode == MODE_ONESHOT) begin
        case (state_q)
          ST_RUN: begin
            if (trig_ev || os_sw_q) begin
              cnt_q <= reload_q;
            end else if (tick && cnt_q <= 16'h0001) begin
              cnt_q   <= reload_q;
              out_q   <= 1'b0;
              state_q <= ST_HALT;
              ev_q[EV_ZERO_B] <= 1'b1;
            end else if (tick) begin
              cnt_q <= cnt_q - 16'h0001;
            end
          end
          default: begin
            state_q <= ST_HALT;
            if (trig_ev || os_sw_q) begin
              cnt_q   <= reload_q;
              out_q   <= 1'b1;      // pulse of n count clocks
              state_q <= ST_RUN;
            end else if (cnt_wr) begin
              cnt_q <= cnt_wv[15:0];
            end
          end
        endcase
      end else begin
        case (state_q)
          ST_RUN: begin
            // triggers are not looked at here
            if (sub_tick) begin
              pre_q <= m_q;
              if (per_q == 16'h0000) begin
                // next period, reload at the rising edge
                per_q <= top_v;
                cnt_q <= width_v;
                m_q   <= ctrl_q.pwm8 ? reload_q[7:0] : 8'h00;
                pre_q <= ctrl_q.pwm8 ? reload_q[7:0] : 8'h00;
                out_q <= (width_v != 16'h0000);
                if (out_q && width_v == 16'h0000) begin
                  ev_q[EV_FALL_B] <= 1'b1;
                end
              end else begin
                per_q <= per_q - 16'h0001;
                if (cnt_q != 16'h0000) begin
                  cnt_q <= cnt_q - 16'h0001;
                end
                if (cnt_q == 16'h0001) begin
                  out_q <= 1'b0;
                  ev_q[EV_FALL_B] <= 1'b1;
                end
              end
            end else if (tick) begin
              pre_q <= pre_q - 8'h01;
            end
          end
          default: begin
            // without a trigger source the run flag alone starts
            state_q <= ST_WAIT;
            if (trig_ev || !(ctrl_q.ext_trig_en || ctrl_q.ovf_trig_en)) begin
              state_q <= ST_RUN;
              per_q   <= top_v;
              cnt_q   <= width_v;
              m_q     <= ctrl_q.pwm8 ? reload_q[7:0] : 8'h00;
              pre_q   <= ctrl_q.pwm8 ? reload_q[7:0] : 8'h00;
              out_q   <= (width_v != 16'h0000);
            end
          end
        endcase
      end
    end
  end

  // output pin: pulse or gpio in one-shot, always pulse in pwm
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= (ctrl_q.pulse_en || ctrl_q.mode == MODE_PWM) ? out_q
               : gpio_out_q;
    end
  end

  assign o_awready          = awready_q;
  assign o_wready           = wready_q;
  assign o_bvalid           = bvalid_q;
  assign o_bresp            = bresp_q;
  assign o_arready          = arready_q;
  assign o_rvalid           = rvalid_q;
  assign o_rdata            = rdata_q;
  assign o_rresp            = rresp_q;
  assign o_pulse_output_pin = pin_q;
  assign o_irq              = irq_q;

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  a_oneshot_zero_irq: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    (ctrl_q.run && ctrl_q.mode == MODE_ONESHOT && state_q == ST_RUN
     && !trig_ev && !os_sw_q && tick && cnt_q <= 16'h0001)
    |=> ev_q[EV_ZERO_B] ##1 sts_q[EV_ZERO_B])
    else $error("one-shot zero did not raise status");
  a_oneshot_halt: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    (ctrl_q.run && ctrl_q.mode == MODE_ONESHOT && state_q == ST_RUN
     && !trig_ev && !os_sw_q && tick && cnt_q <= 16'h0001)
    |=> state_q == ST_HALT && !out_q && cnt_q == $past(reload_q))
    else $error("one-shot did not reload and halt at zero");
  a_oneshot_retrig: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    (ctrl_q.run && ctrl_q.mode == MODE_ONESHOT && state_q == ST_RUN
     && trig_ev) |=> cnt_q == $past(reload_q) && state_q == ST_RUN)
    else $error("retrigger did not reload the counter");
  a_run_clear: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    !ctrl_q.run |=> state_q == ST_HALT ##1 !pin_q || !ctrl_q.pulse_en)
    else $error("cleared run flag did not stop the counter");
  a_halted_write: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    (cnt_wr && state_q == ST_HALT && !trig_ev && !os_sw_q
     && ctrl_q.mode == MODE_ONESHOT) |=> cnt_q == reload_q)
    else $error("halted write missed the counter");
  a_count_read: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    (i_arvalid && arready_q && i_araddr == OFF_COUNT)
    |=> rvalid_q && rdata_q == COUNT_RDVAL)
    else $error("count read returned live state");
  a_pwm_no_trig: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    (ctrl_q.run && ctrl_q.mode == MODE_PWM && state_q == ST_RUN
     && trig_ev && !tick) |=> $stable(cnt_q) && $stable(per_q))
    else $error("pwm counter moved on a trigger");
  a_pwm_fall_irq: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    (ctrl_q.run && $past(ctrl_q.run) && ctrl_q.mode == MODE_PWM
     && $fell(out_q)) |-> ev_q[EV_FALL_B])
    else $error("pwm falling edge gave no interrupt event");
  a_pwm_wrap: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    (ctrl_q.run && ctrl_q.mode == MODE_PWM && state_q == ST_RUN
     && sub_tick && per_q == 16'h0000)
    |=> per_q == $past(top_v) && cnt_q == $past(width_v))
    else $error("pwm period did not restart at its top");
  a_tick_undiv: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    ctrl_q.clk_sel == CLK_DIV1 |-> tick)
    else $error("undivided count clock missed a cycle");
  a_irq_level: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    |(sts_q & mask_q) |=> o_irq)
    else $error("unmasked status did not raise interrupt");
endmodule
`default_nettype wire

// ===== inc/opt_pkg.sv
// package for the one-shot / pwm timer channel: register map, fields,
// reset values, divider and period constants.
// assumes a single 125 MHz core clock and an axi4-lite register master.
`default_nettype none
package opt_pkg;
  // ---------------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_COUNT   = 8'h04;
  localparam logic [7:0]  OFF_STATUS  = 8'h08;
  localparam logic [7:0]  OFF_MASK    = 8'h0C;
  localparam logic [7:0]  OFF_GPIO    = 8'h10;
  localparam logic [31:0] COUNT_RDVAL = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------------
  localparam int          CTRL_W      = 11;
  localparam int          OS_START_B  = 1;
  localparam int          EV_ZERO_B   = 0;
  localparam int          EV_FALL_B   = 1;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  localparam logic [15:0] RELOAD_RST  = 16'h0000;
  localparam logic [1:0]  MODE_ONESHOT = 2'h0;
  localparam logic [1:0]  MODE_PWM     = 2'h1;
  localparam logic [1:0]  CLK_DIV1   = 2'h0;
  localparam logic [1:0]  CLK_DIV8   = 2'h1;
  localparam logic [1:0]  CLK_DIV32  = 2'h2;
  localparam logic [1:0]  CLK_SUB32  = 2'h3;
  // ---------------------------------------------------------------------
  // dividers and pwm periods (in count clocks, minus one)
  // ---------------------------------------------------------------------
  localparam logic [4:0]  DIV8_LAST  = 5'h07;
  localparam logic [4:0]  DIV32_LAST = 5'h1F;
  localparam logic [15:0] PER16_TOP  = 16'hFFFE;
  localparam logic [15:0] PER8_TOP   = 16'h00FE;
  // control register layout, msb first
  typedef struct packed {
    logic       trig_fall;   // trigger on falling edge of pin
    logic       pulse_en;    // output pin carries the pulse
    logic       ovf_trig_en; // overflow of other timer triggers
    logic       ext_trig_en; // input pin triggers
    logic [1:0] clk_sel;
    logic       pwm8;
    logic [1:0] mode;
    logic       os_start;    // write-one pulse, reads zero
    logic       run;         // count start flag
  } opt_ctrl_t;
  typedef enum logic [1:0] {
    ST_HALT = 2'b00,
    ST_RUN  = 2'b01,
    ST_WAIT = 2'b11
  } opt_state_t;
endpackage
`default_nettype wire

// ===== dv/opt_load.sv
// far side of the timer: trigger source, subclock and a pulse load
// that times the high phase and the period of the output pin.
// assumes the pin is sampled on the core clock rising edge.
`timescale 1ns/1ps
`default_nettype none
module opt_load (
  input  wire logic        i_core_clk,
  input  wire logic        i_fire,
  input  wire logic        i_pulse,
  output var  logic        o_trig,
  output var  logic        o_sub,
  output var  logic [31:0] o_hi,
  output var  logic [31:0] o_per
);
  logic [31:0] hc_q;
  logic [31:0] pc_q;
  logic [3:0]  sc_q;
  logic        pq_q;
  initial begin
    {hc_q, pc_q, o_hi, o_per} = '0;
    {sc_q, pq_q, o_trig, o_sub} = '0;
  end
  // trigger follows the bench request; subclock runs free at clk/16
  always @(posedge i_core_clk) begin
    o_trig <= i_fire;
    sc_q <= sc_q + 4'h1;
    o_sub <= sc_q[3];
    pq_q <= i_pulse;
    hc_q <= i_pulse ? hc_q + 1 : '0;
    pc_q <= pc_q + 1;
    if (pq_q && !i_pulse) o_hi <= hc_q;
    if (!pq_q && i_pulse) begin
      o_per <= pc_q;
      pc_q <= 32'h1;
    end
  end
endmodule
`default_nettype wire

// ===== dv/opt_timer_tb.sv
// bench: axi4-lite master tasks, random counts, pulse timing checks.
// assumes the register map and timing of the opt_pkg package.
`timescale 1ns/1ps
`default_nettype none
module opt_timer_tb;
  import opt_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, ovf = 1'b0, fire = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0]  awa = '0, ara = '0;
  logic [31:0] wd = '0, rdat, rd, hi, per;
  logic [1:0]  br, rr, bres, rres;
  logic        awr, wrdy, bv, arr, rv, trig, sub, pulse, irq;
  int          fails = 0, checked = 0, cyc = 0;
  opt_ctrl_t   c;
  logic [15:0] n, m;
  opt_timer u_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_awaddr(awa),
    .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hF),
    .i_wvalid(wv), .o_wready(wrdy), .o_bresp(br), .o_bvalid(bv),
    .i_bready(bry), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr),
    .o_rdata(rdat), .o_rresp(rr), .o_rvalid(rv), .i_rready(rry),
    .i_trigger_input_pin(trig), .i_subclock(sub), .i_timer_ovf(ovf),
    .o_pulse_output_pin(pulse), .o_irq(irq));
  opt_load u_load (.i_core_clk(clk), .i_fire(fire), .i_pulse(pulse),
    .o_trig(trig), .o_sub(sub), .o_hi(hi), .o_per(per));
  always #4 clk = ~clk;
  // hang guard, well above the longest sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  // each channel released at its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    {awv, wv, bry} <= 3'b111;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv);
    bres = br;
    bry <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    {arv, rry} <= 2'b11;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rd = rdat;
    rres = rr;
    rry <= 1'b0;
  endtask
  task automatic wirq();
    while (irq !== 1'b1) @(posedge clk);
  endtask
  function automatic int div(input int s);
    return (s == 0) ? 1 : (s == 1) ? 8 : (s == 2) ? 32 : 512;
  endfunction
  initial begin
    void'($urandom(82));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdr(OFF_CTRL);
    chk("ctrl", rd, 32'(CTRL_RST));
    rdr(OFF_COUNT);
    chk("count", rd, COUNT_RDVAL);
    rdr(8'h14);
    chk("rresp", 32'(rres), 32'(RESP_SLVERR));
    wr(8'h14, '0);
    chk("bresp", 32'(bres), 32'(RESP_SLVERR));
    wr(OFF_MASK, 32'h3);
    wr(OFF_GPIO, 32'h1);
    @(posedge clk);
    chk("gpio_pin", 32'(pulse), 32'h1);
    wr(OFF_GPIO, 32'h0);
    // one-shot by software start at all four count clocks; first tick
    // may land anywhere inside a divided period, so allow one tick short
    // subclock/32 is 512 core cycles a tick here, so keep n small
    for (int s = 0; s < 4; s++) begin
      n = 16'($urandom_range(2, (s == 3) ? 4 : 40));
      c = '0;
      {c.run, c.pulse_en, c.clk_sel} = {2'b11, 2'(s)};
      wr(OFF_COUNT, 32'(n));
      wr(OFF_CTRL, 32'(c));
      c.os_start = 1'b1;
      wr(OFF_CTRL, 32'(c));
      wirq();
      chk("os_hi", 32'(hi > (n-1)*div(s) && hi <= n*div(s)), 1);
      rdr(OFF_STATUS);
      chk("os_st", rd, 32'h1);
      wr(OFF_STATUS, 32'h3);
      repeat (3) @(posedge clk);
      chk("irq", 32'(irq), 32'h0);
    end
    // pin trigger, then a second one ten cycles later restarts it
    n = 16'($urandom_range(20, 60));
    c = '0;
    {c.run, c.pulse_en, c.ext_trig_en} = 3'b111;
    wr(OFF_COUNT, 32'(n));
    wr(OFF_CTRL, 32'(c));
    fire <= 1'b1;
    repeat (5) @(posedge clk);
    fire <= 1'b0;
    repeat (5) @(posedge clk);
    fire <= 1'b1;
    wirq();
    chk("retrig", hi, 32'(n) + 10);
    wr(OFF_STATUS, 32'h3);
    // prescaled pwm started by the other timer's overflow
    m = 16'($urandom_range(0, 3));
    n = 16'($urandom_range(1, 200));
    c = '0;
    {c.run, c.pulse_en, c.pwm8, c.ovf_trig_en} = 4'hF;
    c.mode = MODE_PWM;
    wr(OFF_COUNT, 32'({n[7:0], m[7:0]}));
    wr(OFF_CTRL, 32'(c));
    repeat (20) @(posedge clk);
    chk("pwm_idle", 32'(pulse), 32'h0);
    for (int k = 0; k < 2; k++) begin
      ovf <= 1'b1;
      @(posedge clk);
      ovf <= 1'b0;
      repeat (3 * 255 * (m + 1)) @(posedge clk);
      chk("pwm_hi", hi, 32'(n * (m + 1)));
      chk("pwm_per", per, 32'(255 * (m + 1)));
      chk("pwm_irq", 32'(irq), 32'h1);
      n = 16'($urandom_range(1, 200));
      wr(OFF_COUNT, 32'({n[7:0], m[7:0]}));
    end
    c.run = 1'b0;
    wr(OFF_CTRL, 32'(c));
    repeat (3) @(posedge clk);
    chk("pwm_stop", 32'(pulse), 32'h0);
    rdr(OFF_STATUS);
    chk("pwm_st", rd, 32'h2);
    end_of_test();
  end
endmodule
`default_nettype wire
